/* rbc_params.svh */
/*
 Constants of the bus-attached clock/calendar core: offsets, bit positions,
 field limits, reset values and timing. Assumes inclusion by the package and
 the core only.
*/
// Notes on behaviour
// - Address on bus before strobe falls; low seven bits latched at that fall.
// - Read drives eight data bits from the read strobe fall; releases when it rises.
// - Access only with chip select held through strobe; address latches regardless.
// - Supply below threshold forces chip select inactive; no access reaches storage.
// - Interrupt output low while any flag is set with its enable.
// - Reading status register C or the init input clears pending interrupts.
// - Interrupt output is open drain: pulls low only, otherwise floats.
// - Init input leaves time counts, calendar and storage bytes untouched.
// - Init low with good supply clears enables, square enable, flags; floats interrupt.
// - All host accesses refused while init input is low.
// - Map: time bytes 00-09, control 0A-0D, 114 storage bytes 0E-7F.
// - Registers C, D, bit 7 of A and seconds top bit are read-only.
// - All ten time bytes share binary or BCD format; increments use it.
// - 12-hour mode: top hour bit marks PM, hours 1-12; 24-hour 0-23.
// - Each second time advances by one, then alarms are checked.
// - Alarm condition when hour, minute, second alarms match; interrupt needs enable.
// - Alarm byte with both top bits set matches any value.
// - Field ranges: seconds, minutes 0-59; weekday 1-7; date 1-31; month 1-12; year 0-99.
// - Reading C clears flags; events during the read are posted after it.
// - Update inhibit freezes host copy; internal copy keeps advancing.
`ifndef RBC_PARAMS_SVH
`define RBC_PARAMS_SVH
`define RBC_MCLK_NS 40
`define RBC_SEC_NS 1000000000
`define RBC_CNT_W 32
`define RBC_SEC 7'h00
`define RBC_SEC_AL 7'h01
`define RBC_MIN 7'h02
`define RBC_MIN_AL 7'h03
`define RBC_HR 7'h04
`define RBC_HR_AL 7'h05
`define RBC_WDAY 7'h06
`define RBC_DATE 7'h07
`define RBC_MON 7'h08
`define RBC_YEAR 7'h09
`define RBC_TIME_BYTES 7'h0A
`define RBC_REG_A 7'h0A
`define RBC_REG_B 7'h0B
`define RBC_REG_C 7'h0C
`define RBC_REG_D 7'h0D
`define RBC_B_SET 7
`define RBC_B_PIE 6
`define RBC_B_AIE 5
`define RBC_B_UIE 4
`define RBC_B_SQUARE_OUT_ENABLE 3
`define RBC_B_DM 2
`define RBC_B_H24 1
`define RBC_INIT_MASK 8'h78
`define RBC_D_VALID 8'h80
`define RBC_DONT_CARE 2'h3
`define RBC_MAX_MS 8'h3B
`define RBC_MAX_H24 8'h17
`define RBC_H12 8'h0C
`define RBC_H11 8'h0B
`define RBC_MAX_WDAY 8'h07
`define RBC_MAX_MON 8'h0C
`define RBC_MAX_YEAR 8'h63
`define RBC_FEB 8'h02
`endif

/* rbc_pkg.sv */
/*
 Types of the bus-attached clock/calendar core.
 Assumes rbc_params.svh on the include path.
*/
`include "rbc_params.svh"
package rbc_pkg;
    typedef struct packed {
        logic [2:0] as_sy;
        logic [2:0] cs_sy;
        logic [2:0] rd_sy;
        logic [2:0] wr_sy;
        logic [2:0] in_sy;
        logic [2:0] lo_sy;
        logic as_f;
        logic cs_f;
        logic rd_f;
        logic wr_f;
        logic in_f;
        logic lo_f;
        logic [2:0][7:0] bus_sy;
        logic [6:0] addr;
        logic rd_ok;
        logic wr_ok;
        logic c_rd;
        logic [7:0] rdat;
        logic [7:0] wdat;
        logic [127:0][7:0] ram;
        logic [9:0][7:0] tk;
        logic [6:0] reg_a;
        logic [7:0] reg_b;
        logic uf;
        logic af;
        logic pf;
        logic h_uf;
        logic h_af;
        logic h_pf;
        logic [`RBC_CNT_W-1:0] sec_cnt;
    } rbc_state_t;
endpackage

/* rbc_core.sv */
/*
 Clock/calendar core behind a multiplexed strobed host bus, with storage bytes,
 alarm and open-drain interrupt. Assumes asynchronous host pins, a 25 MHz mclk
 and a synchronous active-high rst.
*/
`include "rbc_params.svh"
module rbc_core #(
    parameter int unsigned SEC_CYCLES = `RBC_SEC_NS / `RBC_MCLK_NS
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic rst,
    // Multiplexed host bus
    input wire logic address_latch_strobe,
    input wire logic chip_sel_n,
    input wire logic read_strobe_n,
    input wire logic write_strobe_n,
    input wire logic [7:0] shared_addr_data_bus_in,
    output logic [7:0] shared_addr_data_bus_out,
    output logic shared_addr_data_bus_oe,
    // Init input and supply monitor
    input wire logic init_n,
    input wire logic supply_low,
    // Open-drain interrupt line
    input wire logic irq_n_in,
    output logic irq_n_out,
    output logic irq_n_oe
);
    rbc_pkg::rbc_state_t st_ff;
    rbc_pkg::rbc_state_t nxt_st;
    logic as_fall, rd_fall, rd_rise, wr_fall, wr_rise;
    logic acc_en, init_clr, tick, hit, wr_go, c_end, summary_int_flag;
    logic uf_ev, af_ev;
    logic [9:0][7:0] nt;
    logic [7:0] rd_byte, wd;

    function automatic logic filt(input logic [2:0] sy, input logic f);
        return (sy[1] == sy[2]) ? sy[2] : f;
    endfunction

    function automatic logic [7:0] to_fmt(input logic [7:0] n, input logic bcd);
        logic [7:0] t;
        logic [7:0] u;
        t = n / 8'h0A;
        u = n - t * 8'h0A;
        return bcd ? {t[3:0], u[3:0]} : n;
    endfunction

    function automatic logic [7:0] from_fmt(input logic [7:0] v, input logic bcd);
        return bcd ? ({4'h0, v[7:4]} * 8'h0A) + {4'h0, v[3:0]} : v;
    endfunction

    function automatic logic [7:0] bump(input logic [7:0] v, input logic bcd);
        return (bcd && v[3:0] == 4'h9) ? {v[7:4] + 4'h1, 4'h0} : v + 8'h01;
    endfunction

    function automatic logic [7:0] wrap(input logic [7:0] v, input logic [7:0] hi,
                                        input logic [7:0] lo, input logic bcd);
        return (v == to_fmt(hi, bcd)) ? to_fmt(lo, bcd) : bump(v, bcd);
    endfunction

    function automatic logic [7:0] mlen(input logic [7:0] m, input logic [7:0] y);
        unique case (m)
            8'h04, 8'h06, 8'h09, 8'h0B: mlen = 8'h1E;
            `RBC_FEB: mlen = (y[1:0] == 2'h0) ? 8'h1D : 8'h1C;
            default: mlen = 8'h1F;
        endcase
    endfunction

    function automatic logic am(input logic [7:0] a, input logic [7:0] v);
        return (a[7:6] == `RBC_DONT_CARE) || (a == v);
    endfunction

    function automatic logic [9:0][7:0] advance(input logic [9:0][7:0] t,
                                                input logic bcd, input logic h24);
        logic [9:0][7:0] n;
        logic [7:0] hr;
        logic [7:0] w;
        logic day;
        n = t;
        day = 1'b0;
        hr = {1'b0, t[`RBC_HR][6:0]};
        w = wrap(hr, `RBC_H12, 8'h01, bcd);
        n[`RBC_SEC] = wrap(t[`RBC_SEC], `RBC_MAX_MS, 8'h00, bcd);
        if (t[`RBC_SEC] == to_fmt(`RBC_MAX_MS, bcd)) begin
            n[`RBC_MIN] = wrap(t[`RBC_MIN], `RBC_MAX_MS, 8'h00, bcd);
            if (t[`RBC_MIN] == to_fmt(`RBC_MAX_MS, bcd)) begin
                if (h24) begin
                    n[`RBC_HR] = wrap(t[`RBC_HR], `RBC_MAX_H24, 8'h00, bcd);
                    day = (t[`RBC_HR] == to_fmt(`RBC_MAX_H24, bcd));
                end else if (hr == to_fmt(`RBC_H11, bcd)) begin
                    n[`RBC_HR] = {~t[`RBC_HR][7], to_fmt(`RBC_H12, bcd)[6:0]};
                    day = t[`RBC_HR][7];
                end else begin
                    n[`RBC_HR] = {t[`RBC_HR][7], w[6:0]};
                end
            end
        end
        if (day) begin
            n[`RBC_WDAY] = wrap(t[`RBC_WDAY], `RBC_MAX_WDAY, 8'h01, bcd);
            n[`RBC_DATE] = bump(t[`RBC_DATE], bcd);
            if (from_fmt(t[`RBC_DATE], bcd) == mlen(from_fmt(t[`RBC_MON], bcd),
                                                   from_fmt(t[`RBC_YEAR], bcd))) begin
                n[`RBC_DATE] = to_fmt(8'h01, bcd);
                n[`RBC_MON] = wrap(t[`RBC_MON], `RBC_MAX_MON, 8'h01, bcd);
                if (t[`RBC_MON] == to_fmt(`RBC_MAX_MON, bcd)) begin
                    n[`RBC_YEAR] = wrap(t[`RBC_YEAR], `RBC_MAX_YEAR, 8'h00, bcd);
                end
            end
        end
        return n;
    endfunction

    always_comb begin
        nxt_st = st_ff;
        wd = st_ff.wdat;
        // Three stages; a level counts once stages two and three agree
        nxt_st.as_sy = {st_ff.as_sy[1:0], address_latch_strobe};
        nxt_st.cs_sy = {st_ff.cs_sy[1:0], chip_sel_n};
        nxt_st.rd_sy = {st_ff.rd_sy[1:0], read_strobe_n};
        nxt_st.wr_sy = {st_ff.wr_sy[1:0], write_strobe_n};
        nxt_st.in_sy = {st_ff.in_sy[1:0], init_n};
        nxt_st.lo_sy = {st_ff.lo_sy[1:0], supply_low};
        nxt_st.bus_sy = {st_ff.bus_sy[1:0], shared_addr_data_bus_in};
        nxt_st.as_f = filt(st_ff.as_sy, st_ff.as_f);
        nxt_st.cs_f = filt(st_ff.cs_sy, st_ff.cs_f);
        nxt_st.rd_f = filt(st_ff.rd_sy, st_ff.rd_f);
        nxt_st.wr_f = filt(st_ff.wr_sy, st_ff.wr_f);
        nxt_st.in_f = filt(st_ff.in_sy, st_ff.in_f);
        nxt_st.lo_f = filt(st_ff.lo_sy, st_ff.lo_f);
        as_fall = st_ff.as_f & ~nxt_st.as_f;
        rd_fall = st_ff.rd_f & ~nxt_st.rd_f;
        rd_rise = ~st_ff.rd_f & nxt_st.rd_f;
        wr_fall = st_ff.wr_f & ~nxt_st.wr_f;
        wr_rise = ~st_ff.wr_f & nxt_st.wr_f;
        acc_en = st_ff.in_f & ~st_ff.lo_f & ~st_ff.cs_f;
        init_clr = ~st_ff.in_f & ~st_ff.lo_f;
        summary_int_flag = (st_ff.uf & st_ff.reg_b[`RBC_B_UIE]) | (st_ff.af & st_ff.reg_b[`RBC_B_AIE])
             | (st_ff.pf & st_ff.reg_b[`RBC_B_PIE]);
        // Address latch runs even without chip select
        if (as_fall) begin
            nxt_st.addr = st_ff.bus_sy[2][6:0];
        end
        unique case (st_ff.addr)
            `RBC_REG_A: rd_byte = {1'b0, st_ff.reg_a};
            `RBC_REG_B: rd_byte = st_ff.reg_b;
            `RBC_REG_C: rd_byte = {summary_int_flag, st_ff.pf, st_ff.af, st_ff.uf, 4'h0};
            `RBC_REG_D: rd_byte = `RBC_D_VALID;
            default: rd_byte = st_ff.ram[st_ff.addr];
        endcase
        // Read data is caught at strobe fall so it stays stable all cycle
        c_end = rd_rise & st_ff.c_rd;
        if (rd_fall) begin
            nxt_st.rd_ok = acc_en;
            nxt_st.c_rd = acc_en && (st_ff.addr == `RBC_REG_C);
            nxt_st.rdat = rd_byte;
        end else if (rd_rise || !acc_en) begin
            nxt_st.rd_ok = 1'b0;
            nxt_st.c_rd = 1'b0;
        end
        // Last value seen while the write strobe is low is the one stored
        if (!st_ff.wr_f) begin
            nxt_st.wdat = st_ff.bus_sy[2];
        end
        wr_go = wr_rise & st_ff.wr_ok;
        if (wr_fall) begin
            nxt_st.wr_ok = acc_en;
        end else if (wr_rise || !acc_en) begin
            nxt_st.wr_ok = 1'b0;
        end
        // Once-per-second update
        tick = (st_ff.sec_cnt == `RBC_CNT_W'(SEC_CYCLES - 1));
        nxt_st.sec_cnt = tick ? '0 : st_ff.sec_cnt + `RBC_CNT_W'(1);
        nt = advance(st_ff.tk, st_ff.reg_b[`RBC_B_DM], st_ff.reg_b[`RBC_B_H24]);
        hit = am(nt[`RBC_SEC_AL], nt[`RBC_SEC]) && am(nt[`RBC_MIN_AL], nt[`RBC_MIN])
            && am(nt[`RBC_HR_AL], nt[`RBC_HR]);
        uf_ev = tick & ~st_ff.reg_b[`RBC_B_SET];
        af_ev = tick & hit;
        if (tick) begin
            nxt_st.tk = nt;
            if (!st_ff.reg_b[`RBC_B_SET]) begin
                nxt_st.ram[9:0] = nt;
                nxt_st.ram[`RBC_SEC][7] = 1'b0;
            end
        end
        // Clear on status read; set wins over the clear
        if (c_end) begin
            nxt_st.uf = st_ff.h_uf | uf_ev;
            nxt_st.af = st_ff.h_af | af_ev;
            nxt_st.pf = st_ff.h_pf;
            nxt_st.h_uf = 1'b0;
            nxt_st.h_af = 1'b0;
            nxt_st.h_pf = 1'b0;
        end else if (st_ff.c_rd) begin
            nxt_st.h_uf = st_ff.h_uf | uf_ev;
            nxt_st.h_af = st_ff.h_af | af_ev;
        end else begin
            nxt_st.uf = st_ff.uf | uf_ev;
            nxt_st.af = st_ff.af | af_ev;
        end
        // Host write follows the update so it wins on the same byte
        if (wr_go) begin
            if (st_ff.addr < `RBC_TIME_BYTES) begin
                if (st_ff.addr == `RBC_SEC) begin
                    wd[7] = st_ff.ram[`RBC_SEC][7];
                end
                nxt_st.ram[st_ff.addr] = wd;
                nxt_st.tk[st_ff.addr[3:0]] = wd;
            end else if (st_ff.addr == `RBC_REG_A) begin
                nxt_st.reg_a = st_ff.wdat[6:0];
            end else if (st_ff.addr == `RBC_REG_B) begin
                nxt_st.reg_b = st_ff.wdat;
            end else if (st_ff.addr > `RBC_REG_D) begin
                nxt_st.ram[st_ff.addr] = st_ff.wdat;
            end
        end
        // Init touches control and flags only, never time or storage
        if (init_clr) begin
            nxt_st.reg_b = st_ff.reg_b & ~`RBC_INIT_MASK;
            nxt_st.uf = 1'b0;
            nxt_st.af = 1'b0;
            nxt_st.pf = 1'b0;
            nxt_st.h_uf = 1'b0;
            nxt_st.h_af = 1'b0;
            nxt_st.h_pf = 1'b0;
        end
        if (rst) begin
            nxt_st = '0;
            nxt_st.cs_sy = 3'h7;
            nxt_st.rd_sy = 3'h7;
            nxt_st.wr_sy = 3'h7;
            nxt_st.in_sy = 3'h7;
            nxt_st.cs_f = 1'b1;
            nxt_st.rd_f = 1'b1;
            nxt_st.wr_f = 1'b1;
            nxt_st.in_f = 1'b1;
        end
    end

    always_ff @(posedge mclk) begin
        st_ff <= nxt_st;
    end

    assign shared_addr_data_bus_out = st_ff.rdat;
    assign shared_addr_data_bus_oe = st_ff.rd_ok;
    assign irq_n_out = 1'b0;
    assign irq_n_oe = summary_int_flag & ~init_clr;

    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (rst);

    chk_addr_latch: assert property (as_fall |=> st_ff.addr == $past(st_ff.bus_sy[2][6:0]))
        else $error("address not latched at strobe fall");
    chk_bus_release: assert property (st_ff.rd_f && !$past(st_ff.rd_f) |=> !shared_addr_data_bus_oe)
        else $error("bus still driven after read strobe rose");
    chk_supply_block: assert property (st_ff.lo_f |=> !st_ff.rd_ok && !st_ff.wr_ok)
        else $error("access active during low supply");
    chk_init_refuse: assert property (!st_ff.in_f |=> !shared_addr_data_bus_oe && !st_ff.wr_ok)
        else $error("access active during init");
    chk_irq_level: assert property (st_ff.af && st_ff.reg_b[`RBC_B_AIE] && !init_clr |-> irq_n_oe)
        else $error("interrupt not driven");
    chk_init_clear: assert property (init_clr |=> (st_ff.reg_b & `RBC_INIT_MASK) == 8'h00
                                     && !st_ff.uf && !st_ff.af && !irq_n_oe)
        else $error("init did not clear enables and flags");
    chk_status_clear: assert property (c_end && !tick && !st_ff.h_uf && !st_ff.h_af |=> !st_ff.uf && !st_ff.af
                                       ##0 !st_ff.c_rd)
        else $error("status read did not clear flags");
    chk_sec_top: assert property (!st_ff.ram[`RBC_SEC][7])
        else $error("seconds top bit set");
    chk_alarm_post: assert property (tick && hit && !init_clr |=> st_ff.af || st_ff.h_af)
        else $error("alarm match not flagged");
    chk_freeze: assert property (tick && st_ff.reg_b[`RBC_B_SET] && !wr_go
                                 |=> $stable(st_ff.ram[`RBC_SEC]))
        else $error("host copy changed while inhibited");

    cov_status_read: cover property (c_end);
    cov_alarm_hit: cover property (af_ev);
    cov_irq_seen: cover property (irq_n_oe && !irq_n_in);
    cov_write: cover property (wr_go);
endmodule // rbc_core

/* rbc_host_model.sv */
/*
 Host processor model for the clock/calendar core: drives the multiplexed,
 strobed bus pins and samples the device's answer. Assumes a free-running mclk
 and calls of its access task from the bench, one at a time.
*/
module rbc_host (
    // Clock
    input wire logic mclk,
    // Device side of the bus
    input wire logic [7:0] dev_out,
    input wire logic dev_oe,
    // Host pins
    output logic as_pin,
    output logic cs_n,
    output logic rd_n,
    output logic wr_n,
    output logic [7:0] bus
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] drv;
    logic drv_en;
    logic [7:0] flt;
    // No pull on the bus, so a released bus shows a pattern that flips every cycle
    assign bus = dev_oe ? dev_out : (drv_en ? drv : flt);
    initial begin
        as_pin = 1'b0;
        cs_n = 1'b1;
        rd_n = 1'b1;
        wr_n = 1'b1;
        drv = 8'h00;
        drv_en = 1'b0;
        flt = 8'h5A;
    end
    always @(negedge mclk) begin
        flt <= ~flt;
    end
    // Phases of five to eight cycles keep clear of the three-flop input filter
    task automatic access(input logic wr, input logic sel, input logic [7:0] addr, input logic [7:0] wdata,
                          output logic [7:0] rdata, output logic oe_mid, output logic oe_end);
        @(negedge mclk);
        drv = addr;
        drv_en = 1'b1;
        as_pin = 1'b1;
        // Select settles through the filter before any strobe edge is judged
        cs_n = ~sel;
        repeat (5) @(negedge mclk);
        as_pin = 1'b0;
        repeat (6) @(negedge mclk);
        drv = wdata;
        drv_en = wr;
        wr_n = ~wr;
        rd_n = wr;
        repeat (8) @(negedge mclk);
        oe_mid = dev_oe;
        rdata = dev_out;
        wr_n = 1'b1;
        rd_n = 1'b1;
        repeat (6) @(negedge mclk);
        oe_end = dev_oe;
        cs_n = 1'b1;
        drv_en = 1'b0;
    endtask
endmodule // rbc_host

/* rbc_core_tb_top.sv */
/*
 Self-checking bench for the clock/calendar core: random storage traffic,
 read-only places, select and supply gating, calendar roll-over, alarm and init.
 Assumes rbc_core, rbc_host and a shortened second of SECC cycles.
*/
module rbc_core_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int SECC = 2000;
    localparam logic [6:0] TOFS [7] = '{7'h00, 7'h02, 7'h04, 7'h06, 7'h07, 7'h08, 7'h09};
    logic mclk, rst, init_n, supply_low;
    logic as_pin, cs_n, rd_n, wr_n, dev_oe, irq_out, irq_oe, irq_wire;
    logic [7:0] bus, dev_out, rv;
    logic [7:0] shadow [128];
    int n_fail, total_checks;
    // Pulled-up shared interrupt line
    assign irq_wire = irq_oe ? irq_out : 1'b1;
    rbc_core #(.SEC_CYCLES(SECC)) uut (.mclk(mclk), .rst(rst), .address_latch_strobe(as_pin),
        .chip_sel_n(cs_n), .read_strobe_n(rd_n), .write_strobe_n(wr_n), .shared_addr_data_bus_in(bus),
        .shared_addr_data_bus_out(dev_out), .shared_addr_data_bus_oe(dev_oe), .init_n(init_n),
        .supply_low(supply_low), .irq_n_in(irq_wire), .irq_n_out(irq_out), .irq_n_oe(irq_oe));
    rbc_host host (.mclk(mclk), .dev_out(dev_out), .dev_oe(dev_oe), .as_pin(as_pin), .cs_n(cs_n),
        .rd_n(rd_n), .wr_n(wr_n), .bus(bus));
    initial begin
        mclk = 1'b0;
        forever #20 mclk = ~mclk;
    end
    task automatic close_out;
        $display("checks %0d mismatches %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    task automatic chk8(input string what, input logic [7:0] e, input logic [7:0] g);
        total_checks++;
        if (g !== e) begin
            n_fail++;
            $display("Error %s expected %h seen %h", what, e, g);
        end
    endtask
    task automatic chk1(input string what, input logic e, input logic g);
        total_checks++;
        if (g !== e) begin
            n_fail++;
            $display("Error %s expected %b seen %b", what, e, g);
        end
    endtask
    // ok tells whether the device should answer a read at all
    task automatic acc(input logic wr, input logic sel, input logic [7:0] a, input logic [7:0] d, input logic ok);
        logic om, oe;
        host.access(wr, sel, a, d, rv, om, oe);
        if (!wr) begin
            chk1("read drive", ok, om);
            chk1("read release", 1'b0, oe);
        end
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
        acc(1'b0, 1'b1, a, 8'h00, 1'b1);
        chk8($sformatf("byte at %h", a), e, rv);
    endtask
    function automatic logic [7:0] exp_rb(input logic [6:0] a, input logic [7:0] d);
        case (a)
            7'h00, 7'h0A: return d & 8'h7F;
            7'h0C: return 8'h00;
            7'h0D: return 8'h80;
            default: return d;
        endcase
    endfunction
    task automatic wait_irq;
        int i;
        for (i = 0; i < SECC + 200 && irq_oe !== 1'b1; i++) begin
            @(negedge mclk);
        end
        chk1("irq raised", 1'b1, irq_oe);
    endtask
    // Aligns to a tick first so the byte writes cannot straddle one
    task automatic tick_case(input logic [7:0] mode, input logic [6:0][7:0] t, input logic [6:0][7:0] e);
        int k;
        acc(1'b0, 1'b1, 8'h0C, 8'h00, 1'b1);
        acc(1'b1, 1'b1, 8'h0B, mode | 8'h10, 1'b1);
        wait_irq();
        acc(1'b1, 1'b1, 8'h0B, mode | 8'h80, 1'b1);
        for (k = 0; k < 7; k++) begin
            acc(1'b1, 1'b1, {1'b0, TOFS[k]}, t[k], 1'b1);
        end
        acc(1'b0, 1'b1, 8'h0C, 8'h00, 1'b1);
        acc(1'b1, 1'b1, 8'h0B, mode | 8'h10, 1'b1);
        wait_irq();
        acc(1'b1, 1'b1, 8'h0B, mode | 8'h80, 1'b1);
        for (k = 0; k < 7; k++) begin
            rd_chk({1'b0, TOFS[k]}, e[k]);
        end
        rd_chk(8'h0C, 8'h10);
        chk1("irq after status read", 1'b0, irq_oe);
    endtask
    initial begin
        repeat (60000) @(posedge mclk);
        n_fail++;
        $display("Error watchdog expected finish seen hang");
        close_out();
    end
    initial begin
        int k;
        logic [6:0] a;
        logic [7:0] d;
        rst = 1'b1;
        init_n = 1'b1;
        supply_low = 1'b0;
        n_fail = 0;
        total_checks = 0;
        foreach (shadow[i]) shadow[i] = 8'h00;
        void'($urandom(28779));
        repeat (20) @(negedge mclk);
        rst = 1'b0;
        repeat (2) @(negedge mclk);
        rd_chk(8'h0D, 8'h80);
        // Alarm setting that no time can reach
        for (k = 1; k < 6; k += 2) begin
            acc(1'b1, 1'b1, 8'(k), 8'h3A, 1'b1);
        end
        acc(1'b1, 1'b1, 8'h0B, 8'h80, 1'b1);
        foreach (TOFS[k]) begin
            if (k < 4) begin
                a = (k == 0) ? 7'h00 : 7'(8'h09 + k);
                acc(1'b1, 1'b1, {1'b0, a}, 8'hFF, 1'b1);
                rd_chk({1'b0, a}, exp_rb(a, 8'hFF));
            end
        end
        for (k = 0; k < 16; k++) begin
            a = (k == 0) ? 7'h0E : (k == 1) ? 7'h7F : 7'(14 + $urandom % 114);
            d = 8'($urandom);
            shadow[a] = d;
            acc(1'b1, 1'b1, {1'($urandom), a}, d, 1'b1);
        end
        for (k = 14; k < 128; k++) begin
            rd_chk(8'(k), shadow[k]);
        end
        acc(1'b1, 1'b0, 8'h0E, ~shadow[14], 1'b1);
        acc(1'b0, 1'b0, 8'h0E, 8'h00, 1'b0);
        rd_chk(8'h0E, shadow[14]);
        supply_low = 1'b1;
        acc(1'b1, 1'b1, 8'h7F, ~shadow[127], 1'b1);
        acc(1'b0, 1'b1, 8'h7F, 8'h00, 1'b0);
        supply_low = 1'b0;
        rd_chk(8'h7F, shadow[127]);
        tick_case(8'h02, 56'h04_02_1C_07_17_3B_3B, 56'h04_02_1D_01_00_00_00);
        tick_case(8'h04, 56'h23_04_30_03_91_59_59, 56'h23_05_01_04_12_00_00);
        for (k = 1; k < 6; k += 2) begin
            acc(1'b1, 1'b1, 8'(k), 8'hC0 | 8'($urandom % 64), 1'b1);
        end
        acc(1'b0, 1'b1, 8'h0C, 8'h00, 1'b1);
        acc(1'b1, 1'b1, 8'h0B, 8'h20, 1'b1);
        wait_irq();
        rd_chk(8'h0C, 8'hB0);
        chk1("irq after status read", 1'b0, irq_oe);
        acc(1'b1, 1'b1, 8'h0B, 8'hF8, 1'b1);
        wait_irq();
        acc(1'b1, 1'b1, 8'h01, 8'h3C, 1'b1);
        init_n = 1'b0;
        repeat (8) @(negedge mclk);
        chk1("irq in init", 1'b0, irq_oe);
        acc(1'b1, 1'b1, 8'h0E, ~shadow[14], 1'b1);
        acc(1'b0, 1'b1, 8'h0E, 8'h00, 1'b0);
        init_n = 1'b1;
        repeat (8) @(negedge mclk);
        rd_chk(8'h0B, 8'h80);
        rd_chk(8'h0C, 8'h00);
        rd_chk(8'h0E, shadow[14]);
        close_out();
    end
endmodule // rbc_core_tb_top
